// File: core/sbtc_pkg.sv
// Package for the sixteen bit timer/counter: register map, control
// fields, reset values and timing constants.
// Assumes a 20 MHz system clock that also stands for the oscillator.
package sbtc_pkg;

  // Register byte addresses on the APB slave.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CNT_LOW  = 8'h04;
  localparam logic [7:0] OFS_CNT_HIGH = 8'h08;
  localparam logic [7:0] OFS_FLAG     = 8'h0c;
  localparam logic [7:0] OFS_ENABLE   = 8'h10;
  localparam logic [7:0] OFS_DIR      = 8'h14;
  localparam logic [7:0] OFS_PORT     = 8'h18;

  // Control register field positions.
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_CS    = 1;
  localparam int CTRL_SYNCN = 2;
  localparam int CTRL_OSCEN = 3;
  localparam int CTRL_PS_LO = 4;
  localparam int CTRL_PS_HI = 5;
  localparam logic [7:0] CTRL_MASK = 8'h3f;

  // Flag and enable bit positions, reset values.
  localparam int FLAG_OVF = 0;
  localparam int EN_OVF   = 0;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hffff;
  localparam logic [1:0]  DIR_RESET   = 2'h3;

  // Timing: the instruction clock is the oscillator divided by four.
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int OSC_DIV    = 4;
  localparam logic [1:0] INST_LAST = 2'(OSC_DIV - 1);

endpackage : sbtc_pkg

// File: core/sbtc_prescale.sv
// Input clock prescaler: passes one of every 1, 2, 4 or 8 input ticks.
// Assumes tick_in is a one-cycle pulse on sys_clk.
`timescale 1ns/10ps
module sbtc_prescale (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       clear,
  input  wire logic [1:0] ratio_sel,
  input  wire logic       tick_in,
  output logic            tick_out
);

  typedef struct packed {
    logic [2:0] cnt;
  } sbtc_pre_s;

  sbtc_pre_s st;
  sbtc_pre_s next_st;
  logic [2:0] last;

  // Select code to terminal count: 00->0, 01->1, 10->3, 11->7.
  function automatic logic [2:0] sbtc_last(input logic [1:0] sel);
    sbtc_last = 3'((4'h1 << sel) - 4'h1);
  endfunction : sbtc_last

  assign last     = sbtc_last(ratio_sel);
  assign tick_out = tick_in && (st.cnt >= last);

  // Count input ticks, wrapping at the selected terminal count.
  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.cnt = 3'h0;
    end else if (tick_in) begin
      next_st.cnt = (st.cnt >= last) ? 3'h0 : 3'(st.cnt + 3'h1);
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : sbtc_prescale

// File: core/sbtc_sync2.sv
// Two flip-flop synchroniser for pin inputs.
// Assumes inputs arrive from outside the sys_clk domain.
`timescale 1ns/10ps
module sbtc_sync2 #(
  parameter int W = 2
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sbtc_sync_s;

  sbtc_sync_s st;
  sbtc_sync_s next_st;

  // The first stage is read only by the second stage.
  always_comb begin
    next_st.s1 = din;
    next_st.s2 = st.s1;
  end

  // State register.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.s2;

endmodule : sbtc_sync2

// File: core/sbtc_top.sv
// Sixteen bit timer/counter with APB register access.
// Assumes a 20 MHz sys_clk, an APB master on the same clock, and a
// capture/compare unit on the same clock driving cc_unit_clear.
//
// Notes on behaviour
// - The count is two readable and writable bytes, high and low.
// - The count runs from 0000h to FFFFh and wraps to 0000h.
// - Each wrap sets the overflow flag, which stays until software clears it.
// - The interrupt request is raised only while the overflow enable is set.
// - In timer mode the count advances once per instruction cycle.
// - In counter mode the count advances on each rising external edge.
// - Clock select high picks the external pin, low picks oscillator/4.
// - Run control high lets the counter run, low holds the count.
// - The capture/compare reset input clears the count.
// - With the crystal enabled both shared pins are inputs and read as 0.
// - Prescale select 00, 01 and 11 give 1:1, 1:2 and 1:8.
// - Crystal enable runs the low-power oscillator; clear turns it off.
// - In counter mode sync_disable_n high skips the synchronising stage.
// - In timer mode the synchronise bit is ignored.
// - Control bits 7 and 6 read as zero and ignore writes.
`timescale 1ns/10ps
module sbtc_top (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  input  wire logic        cc_unit_clear,
  input  wire logic [1:0]  port_pin_in,
  output logic      [1:0]  port_pin_out,
  output logic      [1:0]  port_pin_oe,
  output logic             crystal_osc_run,
  output logic             overflow_irq
);

  ////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] count;
    logic        overflow_flag;
    logic        overflow_irq_enable;
    logic [1:0]  port_c_direction;
    logic [1:0]  port_data;
    logic [1:0]  div;
    logic        src_prev;
    logic        edge_q;
    logic [31:0] rdata;
  } sbtc_state_s;

  sbtc_state_s st;
  sbtc_state_s next_st;

  logic [1:0] pins_sync;
  logic       run_control;
  logic       clock_source_select;
  logic       sync_disable_n;
  logic       crystal_osc_enable;
  logic [1:0] prescale_sel;
  logic       setup;
  logic       wr_acc;
  logic       mapped;
  logic       inst_tick;
  logic       ext_src;
  logic       ext_edge;
  logic       pre_in;
  logic       pre_out;
  logic       count_tick;
  logic       wr_low;
  logic       wr_high;
  logic       wr_flag;
  logic       inc;

  ////////////////////////////////////////////////////////////////////////
  // Decode.

  // Address decode shared by reads and writes.
  function automatic logic sbtc_mapped(input logic [7:0] a);
    sbtc_mapped = (a == sbtc_pkg::OFS_CTRL) ||
                  (a == sbtc_pkg::OFS_CNT_LOW) ||
                  (a == sbtc_pkg::OFS_CNT_HIGH) ||
                  (a == sbtc_pkg::OFS_FLAG) ||
                  (a == sbtc_pkg::OFS_ENABLE) ||
                  (a == sbtc_pkg::OFS_DIR) ||
                  (a == sbtc_pkg::OFS_PORT);
  endfunction : sbtc_mapped

  // Control fields.
  assign run_control         = st.ctrl[sbtc_pkg::CTRL_RUN];
  assign clock_source_select = st.ctrl[sbtc_pkg::CTRL_CS];
  assign sync_disable_n      = st.ctrl[sbtc_pkg::CTRL_SYNCN];
  assign crystal_osc_enable  = st.ctrl[sbtc_pkg::CTRL_OSCEN];
  assign prescale_sel        = {st.ctrl[sbtc_pkg::CTRL_PS_HI],
                                st.ctrl[sbtc_pkg::CTRL_PS_LO]};

  // Bus phases: read data is captured in setup, writes land in access.
  assign mapped  = sbtc_mapped(paddr);
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite && mapped;
  assign wr_low  = wr_acc && (paddr == sbtc_pkg::OFS_CNT_LOW);
  assign wr_high = wr_acc && (paddr == sbtc_pkg::OFS_CNT_HIGH);
  assign wr_flag = wr_acc && (paddr == sbtc_pkg::OFS_FLAG);

  // Zero wait state slave; unmapped addresses answer with an error.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = st.rdata;

  ////////////////////////////////////////////////////////////////////////
  // Pins.

  // Both shared pins pass two flip-flops before any logic sees them.
  sbtc_sync2 #(
    .W (2)
  ) u_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .din     (port_pin_in),
    .dout    (pins_sync)
  );

  // The crystal takes both pins as inputs whatever the direction bits.
  assign port_pin_oe     = crystal_osc_enable ? 2'h0 :
                           ~st.port_c_direction;
  assign port_pin_out    = st.port_data;
  assign crystal_osc_run = crystal_osc_enable;

  ////////////////////////////////////////////////////////////////////////
  // Count source.

  // Instruction clock tick, one cycle in four.
  assign inst_tick = (st.div == sbtc_pkg::INST_LAST);

  // Crystal input pin when the oscillator runs, else the clock pin.
  assign ext_src  = crystal_osc_enable ? pins_sync[1] : pins_sync[0];
  assign ext_edge = ext_src && !st.src_prev;

  // Timer mode ignores the synchronise bit entirely.
  assign pre_in = clock_source_select ? ext_edge : inst_tick;

  sbtc_prescale u_pre (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .clear     (wr_low || wr_high),
    .ratio_sel (prescale_sel),
    .tick_in   (pre_in),
    .tick_out  (pre_out)
  );

  // Synchronised counting passes the prescaled edge through one more
  // phase-aligning stage; unsynchronised counting takes it directly.
  assign count_tick = (clock_source_select && !sync_disable_n) ?
                      st.edge_q : pre_out;
  assign inc = run_control && count_tick;

  ////////////////////////////////////////////////////////////////////////
  // Next state.

  // Registers, counter and flag; reset beats count writes, count writes beat counting, a wrap beats a flag write.
  always_comb begin
    next_st          = st;
    next_st.div      = 2'(st.div + 2'h1);
    next_st.src_prev = ext_src;
    next_st.edge_q   = clock_source_select && pre_out;

    // Counter: clear, load a byte, or increment with wrap.
    if (cc_unit_clear) begin
      next_st.count = sbtc_pkg::CNT_RESET;
    end else if (wr_low || wr_high) begin
      if (wr_low) begin
        next_st.count[7:0] = pwdata[7:0];
      end
      if (wr_high) begin
        next_st.count[15:8] = pwdata[7:0];
      end
    end else if (inc) begin
      next_st.count = 16'(st.count + 16'h0001);
    end

    // Other register writes.
    if (wr_acc) begin
      case (paddr)
        sbtc_pkg::OFS_CTRL: begin
          next_st.ctrl = pwdata[7:0] & sbtc_pkg::CTRL_MASK;
        end
        sbtc_pkg::OFS_ENABLE: begin
          next_st.overflow_irq_enable = pwdata[sbtc_pkg::EN_OVF];
        end
        sbtc_pkg::OFS_DIR: begin
          next_st.port_c_direction = pwdata[1:0];
        end
        sbtc_pkg::OFS_PORT: begin
          next_st.port_data = pwdata[1:0];
        end
        default: begin
        end
      endcase
    end

    // Writing 0 clears the flag; a wrap in the same cycle wins.
    if (wr_flag) begin
      next_st.overflow_flag = pwdata[sbtc_pkg::FLAG_OVF];
    end
    if (inc && !cc_unit_clear && !wr_low && !wr_high &&
        (st.count == sbtc_pkg::CNT_MAX)) begin
      next_st.overflow_flag = 1'b1;
    end

    // Read data captured in the setup cycle.
    if (setup && !pwrite) begin
      next_st.rdata = 32'h0000_0000;
      case (paddr)
        sbtc_pkg::OFS_CTRL: begin
          next_st.rdata[7:0] = st.ctrl & sbtc_pkg::CTRL_MASK;
        end
        sbtc_pkg::OFS_CNT_LOW: begin
          next_st.rdata[7:0] = st.count[7:0];
        end
        sbtc_pkg::OFS_CNT_HIGH: begin
          next_st.rdata[7:0] = st.count[15:8];
        end
        sbtc_pkg::OFS_FLAG: begin
          next_st.rdata[sbtc_pkg::FLAG_OVF] = st.overflow_flag;
        end
        sbtc_pkg::OFS_ENABLE: begin
          next_st.rdata[sbtc_pkg::EN_OVF] = st.overflow_irq_enable;
        end
        sbtc_pkg::OFS_DIR: begin
          next_st.rdata[1:0] = st.port_c_direction;
        end
        sbtc_pkg::OFS_PORT: begin
          next_st.rdata[1:0] = crystal_osc_enable ? 2'h0 :
                               pins_sync;
        end
        default: begin
          next_st.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // State register; control clears so the counter starts stopped.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st                     <= '0;
      st.ctrl                <= sbtc_pkg::CTRL_RESET;
      st.count               <= sbtc_pkg::CNT_RESET;
      st.port_c_direction    <= sbtc_pkg::DIR_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Interrupt request gated by the enable bit.
  assign overflow_irq = st.overflow_flag && st.overflow_irq_enable;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // A clean increment from the top of the range.
  sequence wrap_event;
    inc && !cc_unit_clear && !wr_low && !wr_high &&
      (st.count == sbtc_pkg::CNT_MAX);
  endsequence

  sequence quiet_hold;
    !inc && !cc_unit_clear && !wr_low && !wr_high;
  endsequence

  wrap_zero_a: assert property (
    wrap_event |=> (st.count == 16'h0000))
    else $error("count did not wrap to zero");

  wrap_flag_a: assert property (
    wrap_event |=> st.overflow_flag)
    else $error("overflow flag not set on wrap");

  flag_hold_a: assert property (
    (st.overflow_flag && !wr_flag) |=> st.overflow_flag)
    else $error("overflow flag dropped without a clear");

  irq_gate_a: assert property (
    overflow_irq |-> (st.overflow_flag && st.overflow_irq_enable))
    else $error("interrupt raised without flag and enable");

  stop_hold_a: assert property (
    (!run_control && !cc_unit_clear && !wr_low && !wr_high)
      |=> $stable(st.count))
    else $error("stopped counter changed");

  cc_clear_a: assert property (
    cc_unit_clear |=> (st.count == 16'h0000))
    else $error("capture/compare reset did not clear count");

  timer_step_a: assert property (
    (run_control && !clock_source_select && (prescale_sel == 2'h0) &&
     inst_tick && !cc_unit_clear && !wr_low && !wr_high)
      |=> (st.count == 16'($past(st.count) + 16'h0001)))
    else $error("timer mode did not step on instruction tick");

  timer_rate_a: assert property (
    inst_tick |=> !inst_tick [*3] ##1 inst_tick)
    else $error("instruction tick not one in four cycles");

  hold_idle_a: assert property (
    quiet_hold |=> (st.count == $past(st.count)))
    else $error("count moved without a cause");

  pin_release_a: assert property (
    crystal_osc_enable |-> (port_pin_oe == 2'h0))
    else $error("shared pin driven while crystal enabled");

  ctrl_unimpl_a: assert property (
    st.ctrl[7:6] == 2'h0)
    else $error("unimplemented control bits set");

  // Unsynchronised counting steps on the prescaler output itself.
  unsync_step_a: assert property (
    (run_control && clock_source_select && sync_disable_n && pre_out &&
     !cc_unit_clear && !wr_low && !wr_high)
      |=> (st.count == 16'($past(st.count) + 16'h0001)))
    else $error("unsynchronised edge did not step the count");

  // Synchronised counting steps one stage after the prescaler output.
  sync_step_a: assert property (
    (run_control && clock_source_select && !sync_disable_n && st.edge_q &&
     !cc_unit_clear && !wr_low && !wr_high)
      |=> (st.count == 16'($past(st.count) + 16'h0001)))
    else $error("synchronised edge did not step the count");

  // Timer mode feeds the prescaler from the instruction tick alone.
  timer_src_a: assert property (
    !clock_source_select |-> (pre_in == inst_tick))
    else $error("timer mode took a tick from the pins");

endmodule : sbtc_top

// File: tb/sbtc_ext_src.sv
// Far-side model: an external count clock source on the two shared pins.
// Assumes the bench resolves each pin against the design's output enables.
`timescale 1ns/10ps
module sbtc_ext_src #(
  parameter int HALF_NS = 215
) (
  output logic [1:0] pins
);
  logic clk_lvl;

  // The clock stands low between bursts; the crystal pin shows its inverse.
  initial clk_lvl = 1'b0;
  assign pins = {~clk_lvl, clk_lvl};

  // Sends n rising edges; each level lasts well over two system cycles.
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      #(HALF_NS) clk_lvl = 1'b1;
      #(HALF_NS) clk_lvl = 1'b0;
    end
  endtask : burst
endmodule : sbtc_ext_src

// File: tb/tb_sixteen_bit_timer_counter.sv
// Self-checking bench for the timer/counter: APB master, pin partner.
// Assumes sbtc_pkg, sbtc_top and sbtc_ext_src are compiled before it.
`timescale 1ns/10ps
module tb_sixteen_bit_timer_counter;
  logic        sys_clk, arst_n, psel, penable, pwrite, cc_unit_clear;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, crystal_osc_run, overflow_irq, e;
  logic [1:0]  port_pin_in, port_pin_out, port_pin_oe, model_pins;
  logic [15:0] c, v;
  int          err_count, total_checks, n;

  ////////////////////////////////////////////////////////////////////////
  // Design, far-side model and pin resolution.
  sbtc_top DUT (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .cc_unit_clear(cc_unit_clear), .port_pin_in(port_pin_in),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
    .crystal_osc_run(crystal_osc_run), .overflow_irq(overflow_irq));
  sbtc_ext_src ext (.pins(model_pins));
  assign port_pin_in = (port_pin_oe & port_pin_out) |
                       (~port_pin_oe & model_pins);

  // Clock of 50 ns period.
  always #25 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////
  // Counts a comparison and reports a mismatch.
  task automatic check(input string s, input logic [31:0] x,
                       input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // One APB transfer: setup, then access held until pready is sampled.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_count++;
      $display("[FAIL] pready expected 1 seen %b", pready);
      finish_test();
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
  endtask : wr

  task automatic rd_chk(input string s, input logic [7:0] a,
                        input logic [31:0] x);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    check(s, x, r);
  endtask : rd_chk

  // Count access as two bytes; the low write comes last.
  task automatic set_cnt(input logic [15:0] d);
    wr(sbtc_pkg::OFS_CNT_HIGH, {24'h0, d[15:8]});
    wr(sbtc_pkg::OFS_CNT_LOW, {24'h0, d[7:0]});
  endtask : set_cnt

  task automatic get_cnt(output logic [15:0] d);
    logic [31:0] lo, hi;
    logic er;
    apb(1'b0, sbtc_pkg::OFS_CNT_LOW, 32'h0, lo, er);
    apb(1'b0, sbtc_pkg::OFS_CNT_HIGH, 32'h0, hi, er);
    d = {hi[7:0], lo[7:0]};
  endtask : get_cnt

  // Expected timer ticks over a window at prescale select p.
  function automatic int tdelta(input int cyc, input int p);
    return cyc / (sbtc_pkg::OSC_DIV << p);
  endfunction : tdelta

  ////////////////////////////////////////////////////////////////////////
  // Guard against a hang.
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    $display("[FAIL] run length expected end seen timeout");
    finish_test();
  end

  // Main sequence.
  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cc_unit_clear = 1'b0;
    err_count = 0;
    total_checks = 0;
    void'($urandom(64));
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd_chk("ctrl reset", sbtc_pkg::OFS_CTRL, 32'h0);
    check("osc reset", 32'h0, {31'h0, crystal_osc_run});
    wr(sbtc_pkg::OFS_CTRL, 32'hf4);
    rd_chk("ctrl spare", sbtc_pkg::OFS_CTRL, 32'h34);
    // Random byte pairs, held while stopped.
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      set_cnt(v);
      repeat (20) @(posedge sys_clk);
      get_cnt(c);
      check("count held", {16'h0, v}, {16'h0, c});
    end
    // Timer mode at each prescale, synchronise bit random.
    for (int p = 0; p < 4; p++) begin
      set_cnt(16'h0);
      wr(sbtc_pkg::OFS_CTRL, 32'(p << 4) | 32'($urandom % 2 << 2) | 32'h1);
      repeat (798) @(posedge sys_clk);
      wr(sbtc_pkg::OFS_CTRL, 32'h0);
      get_cnt(c);
      n = tdelta(800, p);
      check("timer ticks", 32'h1, {31'h0, (c >= n - 1 && c <= n + 1)});
    end
    // Wrap with the request enabled, then masked, then flag cleared.
    wr(sbtc_pkg::OFS_ENABLE, 32'h1);
    set_cnt(16'hfffd);
    wr(sbtc_pkg::OFS_CTRL, 32'h1);
    repeat (30) @(posedge sys_clk);
    wr(sbtc_pkg::OFS_CTRL, 32'h0);
    get_cnt(c);
    check("wrapped", 32'h1, {31'h0, c < 16'h0010});
    rd_chk("flag set", sbtc_pkg::OFS_FLAG, 32'h1);
    check("irq on", 32'h1, {31'h0, overflow_irq});
    wr(sbtc_pkg::OFS_ENABLE, 32'h0);
    @(negedge sys_clk);
    check("irq masked", 32'h0, {31'h0, overflow_irq});
    rd_chk("flag kept", sbtc_pkg::OFS_FLAG, 32'h1);
    wr(sbtc_pkg::OFS_FLAG, 32'h0);
    rd_chk("flag clear", sbtc_pkg::OFS_FLAG, 32'h0);
    // Capture/compare clear.
    set_cnt(16'($urandom) | 16'h1);
    cc_unit_clear <= 1'b1;
    @(posedge sys_clk);
    cc_unit_clear <= 1'b0;
    get_cnt(c);
    check("cc unit clear", 32'h0, {16'h0, c});
    // Counter mode, synchronised and not; the third pass counts the
    // crystal pin, enabled before the source switches so that the change
    // of pin cannot pose as an edge.
    for (int s = 0; s < 3; s++) begin
      if (s == 2) wr(sbtc_pkg::OFS_CTRL, 32'h8);
      set_cnt(16'h0);
      wr(sbtc_pkg::OFS_CTRL, 32'h3 | 32'(s << 2));
      n = 5 + int'($urandom % 10);
      ext.burst(n);
      repeat (10) @(posedge sys_clk);
      wr(sbtc_pkg::OFS_CTRL, 32'h0);
      get_cnt(c);
      check("edges", 32'(n), {16'h0, c});
    end
    // Pin ownership with and without the crystal.
    wr(sbtc_pkg::OFS_DIR, 32'h0);
    wr(sbtc_pkg::OFS_PORT, 32'h3);
    @(negedge sys_clk);
    check("pin drive", 32'h3, {30'h0, port_pin_oe});
    // The driven levels come back through the two pin flip-flops.
    repeat (2) @(posedge sys_clk);
    rd_chk("port echo", sbtc_pkg::OFS_PORT, 32'h3);
    wr(sbtc_pkg::OFS_CTRL, 32'h8);
    @(negedge sys_clk);
    check("osc on", 32'h1, {31'h0, crystal_osc_run});
    check("pins in", 32'h0, {30'h0, port_pin_oe});
    rd_chk("port zero", sbtc_pkg::OFS_PORT, 32'h0);
    wr(sbtc_pkg::OFS_CTRL, 32'h0);
    @(negedge sys_clk);
    check("osc off", 32'h0, {31'h0, crystal_osc_run});
    // Unmapped address.
    apb(1'b0, 8'h40, 32'h0, q, e);
    check("slverr", 32'h1, {31'h0, e});
    check("unmapped", 32'h0, q);
    finish_test();
  end
endmodule : tb_sixteen_bit_timer_counter
